/* File: hw/serial_slave_unit.sv */
// spi slave with semaphore-guarded buffer dma
// assumes cfg is static while select is low and a
// single-port byte memory acking within one byte time
`timescale 1ns/1ps

module serial_slave_unit (
    // system
    input  logic                clk,
    input  logic                reset,
    input  logic                enable,
    input  sss_pkg::spi_cfg_t   cfg,
    // tasks, one-cycle pulses
    input  logic                task_acquire,
    input  logic                task_release,
    // buffer setup
    input  logic [31:0]         rx_buffer_pointer,
    input  logic [31:0]         tx_buffer_pointer,
    input  logic [9:0]          rx_byte_limit,
    input  logic [9:0]          tx_byte_limit,
    input  logic [7:0]          tx_excess_flag_char,
    input  logic [7:0]          ignored_fill_char,
    // status clears
    input  logic                overflow_clear,
    input  logic                tx_excess_clear,
    // status and events
    output sss_pkg::evt_t       events_q,
    output sss_pkg::sem_owner_t sem_owner_q,
    output logic                overflow_q,
    output logic                tx_excess_flag_q,
    output logic [9:0]          rx_byte_tally_q,
    output logic [9:0]          tx_byte_tally_q,
    // memory port
    output sss_pkg::mem_cmd_t   mem_cmd_q,
    input  logic                mem_ack,
    input  logic [7:0]          mem_rdata,
    // spi pins
    input  logic                sck,
    input  logic                csn_n,
    input  logic                mosi,
    output logic                miso_o,
    output logic                miso_oe_n
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                link_clk;
    logic                link_rst;
    logic [2:0]          smp_cnt_q;
    logic [7:0]          rx_sh_q;
    logic [7:0]          rx_sh_d;
    logic [7:0]          rx_word_q;
    logic                rx_tog_q;
    logic [2:0]          sh_cnt_q;
    logic [2:0]          sh_idx;
    logic                sh_load;
    logic [7:0]          sh_byte;
    logic                first_q;
    logic [7:0]          cur_q;
    logic                out_q;
    logic                tx_tog_q;
    logic [2:0]          sync1_q;
    logic [2:0]          sync2_q;
    logic [2:0]          sync3_q;
    logic                cs_fall;
    logic                cs_rise;
    logic                rx_evt;
    logic                tx_evt;
    sss_pkg::tr_state_t  tr_q;
    logic                start_grant;
    logic                finish;
    logic                give_cpu;
    logic                acq_pend_q;
    logic [7:0]          tx_word_q;
    logic                from_buf_q;
    logic [9:0]          tx_idx_q;
    logic [9:0]          tx_next;
    logic [9:0]          tx_cnt_q;
    logic                tx_pend_q;
    logic [31:0]         tx_base_q;
    logic [31:0]         rx_base_q;
    logic [9:0]          rx_acc_q;
    logic [9:0]          rx_wr_q;
    logic [7:0]          rx_hold_q;
    logic                rx_pend_q;
    logic                wr_done;
    logic                rd_done;
    logic                rx_take;

    // bit picker honouring the order setting
    function automatic logic pick(input logic [7:0] b,
                                  input logic [2:0] i,
                                  input logic       lsb);
        pick = (lsb == sss_pkg::MSB_FIRST) ? b[3'h7 - i] : b[i];
    endfunction

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------

    // folding both mode bits into one clock keeps one sample
    // edge (rising) and one shift edge (falling) for all modes
    assign link_clk = sck ^ cfg.cpol ^ cfg.cpha;

    // a deselected slave holds its bit logic in reset
    assign link_rst = reset | csn_n;

    // assemble incoming bits in the configured order
    always_comb begin
        if (cfg.lsb_first != sss_pkg::MSB_FIRST) begin
            rx_sh_d = {mosi, rx_sh_q[7:1]};
        end else begin
            rx_sh_d = {rx_sh_q[6:0], mosi};
        end
    end

    // sample edge: bit counter and shifter
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            smp_cnt_q <= sss_pkg::BIT_FIRST;
            rx_sh_q   <= sss_pkg::BYTE_ZERO;
        end else begin
            smp_cnt_q <= smp_cnt_q + 3'h1;
            rx_sh_q   <= rx_sh_d;
        end
    end

    // completed byte held stable for a whole byte time,
    // announced by a toggle; survives select rise
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            rx_word_q <= sss_pkg::BYTE_ZERO;
            rx_tog_q  <= 1'b0;
        end else if (smp_cnt_q == sss_pkg::BIT_LAST) begin
            rx_word_q <= rx_sh_d;
            rx_tog_q  <= ~rx_tog_q;
        end
    end

    // phase zero already shows bit 0 before the first edge,
    // so its shift edges carry bits 1..7 of each byte
    assign sh_idx  = sh_cnt_q + {2'b00, ~cfg.cpha};
    assign sh_load = (sh_idx == sss_pkg::BIT_FIRST) || first_q;
    assign sh_byte = sh_load ? tx_word_q : cur_q;

    // shift edge: present the next outgoing bit
    always_ff @(negedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            sh_cnt_q <= sss_pkg::BIT_FIRST;
            first_q  <= 1'b1;
            cur_q    <= sss_pkg::BYTE_ZERO;
            out_q    <= 1'b0;
        end else begin
            sh_cnt_q <= sh_cnt_q + 3'h1;
            first_q  <= 1'b0;
            cur_q    <= sh_byte;
            out_q    <= pick(sh_byte, sh_idx, cfg.lsb_first);
        end
    end

    // toggle tells the system side the staged byte was taken
    always_ff @(negedge link_clk or posedge reset) begin
        if (reset) begin
            tx_tog_q <= 1'b0;
        end else if (sh_load) begin
            tx_tog_q <= ~tx_tog_q;
        end
    end

    // pin drive; the enable follows select directly since no
    // clock edge exists before the first bit is due
    assign miso_o    = (first_q && !cfg.cpha) ?
                       pick(tx_word_q, sss_pkg::BIT_FIRST, cfg.lsb_first) :
                       out_q;
    assign miso_oe_n = csn_n;

    // ------------------------------------------------------------
    // crossing into the system domain
    // ------------------------------------------------------------

    // two stages, then a third only for edge detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_q <= sss_pkg::SYNC_RST;
            sync2_q <= sss_pkg::SYNC_RST;
            sync3_q <= sss_pkg::SYNC_RST;
        end else begin
            sync1_q <= {csn_n, rx_tog_q, tx_tog_q};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign cs_fall = sync3_q[2] & ~sync2_q[2];
    assign cs_rise = ~sync3_q[2] & sync2_q[2];
    assign rx_evt  = sync3_q[1] ^ sync2_q[1];
    assign tx_evt  = sync3_q[0] ^ sync2_q[0];

    // ------------------------------------------------------------
    // transaction and semaphore control
    // ------------------------------------------------------------

    // cpu request in the same cycle beats the slave
    assign start_grant = enable && (tr_q == sss_pkg::TR_IDLE) && cs_fall &&
                         (sem_owner_q == sss_pkg::SEM_FREE) &&
                         !task_acquire;

    // done waits for every outstanding memory access
    assign finish = (tr_q == sss_pkg::TR_DRAIN) && !rx_pend_q &&
                    !tx_pend_q && !mem_cmd_q.req;

    // one grant at most, whatever the mix of causes
    assign give_cpu = acq_pend_q || cfg.end_acquire || task_acquire;

    // transaction state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tr_q <= sss_pkg::TR_IDLE;
        end else if (!enable) begin
            tr_q <= sss_pkg::TR_IDLE;
        end else begin
            case (tr_q)
                sss_pkg::TR_IDLE: begin
                    if (start_grant) begin
                        tr_q <= sss_pkg::TR_GRANT;
                    end else if (cs_fall) begin
                        tr_q <= sss_pkg::TR_IGNORE;
                    end
                end
                sss_pkg::TR_GRANT: begin
                    if (cs_rise) begin
                        tr_q <= sss_pkg::TR_DRAIN;
                    end
                end
                sss_pkg::TR_IGNORE: begin
                    if (cs_rise) begin
                        tr_q <= sss_pkg::TR_IDLE;
                    end
                end
                sss_pkg::TR_DRAIN: begin
                    if (finish) begin
                        tr_q <= sss_pkg::TR_IDLE;
                    end
                end
                default: tr_q <= sss_pkg::TR_IDLE;
            endcase
        end
    end

    // semaphore owner; pointers are plain ports so ownership
    // never gates cpu access
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sem_owner_q <= sss_pkg::SEM_CPU;
            acq_pend_q  <= 1'b0;
        end else if (!enable) begin
            sem_owner_q <= sss_pkg::SEM_CPU;
            acq_pend_q  <= 1'b0;
        end else if (finish) begin
            sem_owner_q <= give_cpu ? sss_pkg::SEM_CPU : sss_pkg::SEM_FREE;
            acq_pend_q  <= 1'b0;
        end else begin
            case (sem_owner_q)
                sss_pkg::SEM_CPU: begin
                    if (task_release && !task_acquire) begin
                        sem_owner_q <= sss_pkg::SEM_FREE;
                    end
                end
                sss_pkg::SEM_FREE: begin
                    if (task_acquire) begin
                        sem_owner_q <= sss_pkg::SEM_CPU;
                    end else if (start_grant) begin
                        sem_owner_q <= sss_pkg::SEM_SLAVE;
                    end
                end
                sss_pkg::SEM_SLAVE: begin
                    if (task_acquire) begin
                        acq_pend_q <= 1'b1;
                    end
                end
                default: sem_owner_q <= sss_pkg::SEM_CPU;
            endcase
        end
    end

    // event pulses, one cycle each
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            events_q <= '0;
        end else begin
            events_q.acquired <= enable && (finish ? give_cpu :
                (task_acquire && sem_owner_q != sss_pkg::SEM_SLAVE));
            events_q.done     <= finish;
            events_q.rx_full  <= wr_done &&
                                 (rx_wr_q + sss_pkg::CNT_ONE == rx_byte_limit);
        end
    end

    // ------------------------------------------------------------
    // buffer data path
    // ------------------------------------------------------------
    assign wr_done = mem_cmd_q.req && mem_cmd_q.we && mem_ack;
    assign rd_done = mem_cmd_q.req && !mem_cmd_q.we && mem_ack;
    assign rx_take = (tr_q == sss_pkg::TR_GRANT) && rx_evt;
    assign tx_next = tx_idx_q + sss_pkg::CNT_ONE;

    // staged transmit byte and read-side bookkeeping
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_word_q  <= sss_pkg::BYTE_ZERO;
            from_buf_q <= 1'b0;
            tx_idx_q   <= sss_pkg::CNT_ZERO;
            tx_cnt_q   <= sss_pkg::CNT_ZERO;
            tx_pend_q  <= 1'b0;
            tx_base_q  <= sss_pkg::ADDR_ZERO;
        end else if (start_grant) begin
            tx_base_q  <= tx_buffer_pointer;
            tx_idx_q   <= sss_pkg::CNT_ZERO;
            tx_cnt_q   <= sss_pkg::CNT_ZERO;
            from_buf_q <= (tx_byte_limit != sss_pkg::CNT_ZERO);
            tx_pend_q  <= (tx_byte_limit != sss_pkg::CNT_ZERO);
            if (tx_byte_limit == sss_pkg::CNT_ZERO) begin
                tx_word_q <= tx_excess_flag_char;
            end
        end else if (enable && tr_q == sss_pkg::TR_IDLE && cs_fall) begin
            tx_word_q  <= ignored_fill_char;
            from_buf_q <= 1'b0;
        end else begin
            if (rd_done) begin
                tx_word_q <= mem_rdata;
                tx_pend_q <= 1'b0;
            end
            if (tr_q == sss_pkg::TR_GRANT && tx_evt && from_buf_q) begin
                tx_cnt_q <= tx_cnt_q + sss_pkg::CNT_ONE;
                if (tx_next < tx_byte_limit) begin
                    tx_idx_q  <= tx_next;
                    tx_pend_q <= 1'b1;
                end else begin
                    tx_word_q  <= tx_excess_flag_char;
                    from_buf_q <= 1'b0;
                end
            end
        end
    end

    // receive side: accept up to the limit, drop the rest
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_base_q <= sss_pkg::ADDR_ZERO;
            rx_acc_q  <= sss_pkg::CNT_ZERO;
            rx_wr_q   <= sss_pkg::CNT_ZERO;
            rx_hold_q <= sss_pkg::BYTE_ZERO;
            rx_pend_q <= 1'b0;
        end else if (start_grant) begin
            rx_base_q <= rx_buffer_pointer;
            rx_acc_q  <= sss_pkg::CNT_ZERO;
            rx_wr_q   <= sss_pkg::CNT_ZERO;
            rx_pend_q <= 1'b0;
        end else begin
            if (wr_done) begin
                rx_wr_q   <= rx_wr_q + sss_pkg::CNT_ONE;
                rx_pend_q <= 1'b0;
            end
            if (rx_take && rx_acc_q < rx_byte_limit) begin
                rx_hold_q <= rx_word_q;
                rx_pend_q <= 1'b1;
                rx_acc_q  <= rx_acc_q + sss_pkg::CNT_ONE;
            end
        end
    end

    // single memory port; writes go first so no received
    // byte waits behind a prefetch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_cmd_q <= '0;
        end else if (mem_cmd_q.req) begin
            if (mem_ack) begin
                mem_cmd_q.req <= 1'b0;
            end
        end else if (rx_pend_q) begin
            mem_cmd_q.req   <= 1'b1;
            mem_cmd_q.we    <= 1'b1;
            mem_cmd_q.addr  <= rx_base_q + {22'h0, rx_wr_q};
            mem_cmd_q.wdata <= rx_hold_q;
        end else if (tx_pend_q) begin
            mem_cmd_q.req   <= 1'b1;
            mem_cmd_q.we    <= 1'b0;
            mem_cmd_q.addr  <= tx_base_q + {22'h0, tx_idx_q};
            mem_cmd_q.wdata <= sss_pkg::BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------

    // sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            overflow_q       <= 1'b0;
            tx_excess_flag_q <= 1'b0;
        end else begin
            overflow_q <= (overflow_q && !overflow_clear) ||
                          (rx_take && rx_acc_q >= rx_byte_limit);
            tx_excess_flag_q <= (tx_excess_flag_q && !tx_excess_clear) ||
                (tr_q == sss_pkg::TR_GRANT && tx_evt && !from_buf_q);
        end
    end

    // tallies only move when a granted transaction completes;
    // reset alone clears them, nothing else shares them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_byte_tally_q <= sss_pkg::CNT_ZERO;
            tx_byte_tally_q <= sss_pkg::CNT_ZERO;
        end else if (finish) begin
            rx_byte_tally_q <= rx_wr_q;
            tx_byte_tally_q <= tx_cnt_q;
        end
    end

endmodule

/* File: include/sss_pkg.sv */
// constants and carrier types for the spi slave with buffer dma
// assumes one system clock domain plus the serial clock domain
// Notes on behaviour
// - all four spi modes via polarity and phase bits; master uses same mode
// - transmit bytes read from ram, receive bytes written to ram, no cpu
// - bytes beyond transmit limit carry the over-read character
// - done event only after every ram access of the transaction ends
// - acquire task requests semaphore; grant shown by acquired event
// - release hands semaphore back; ignored unless cpu holds it
// - semaphore never blocks cpu access to pointers or buffers
// - semaphore starts with cpu on enable, without an acquired event
// - acquire while cpu holds semaphore raises acquired event at once
// - slave tries semaphore at select fall; failure ignores whole transaction
// - simultaneous cpu and slave request: cpu wins
// - granted transaction stores mosi bytes and sends buffer bytes
// - select rise ends granted transaction: semaphore freed, done raised
// - free semaphore allows repeated transactions on unchanged pointers
// - end-acquire shortcut gives semaphore to cpu after each transaction
// - acquire during slave ownership is granted when slave frees it
// - with shortcut and pending acquire only one grant follows done
// - bytes beyond receive limit set overflow and are dropped
// - transmit beyond limit sets over-read flag and sends over-read char
// - tallies updated at end; transmit excludes over-read, receive counts writes
// - buffer-full event once receive buffer completely written
// - no register is cleared by other blocks; software programs everything
// - miso released whenever select is high
// - bit order zero sends msb first, one sends lsb first
// - phase zero samples leading edge; phase one samples trailing edge

package sss_pkg;

    localparam int          BYTE_W    = 8;
    localparam int          LIMIT_W   = 10;
    localparam int          ADDR_W    = 32;
    localparam logic [2:0]  BIT_FIRST = 3'h0;
    localparam logic [2:0]  BIT_LAST  = 3'h7;
    localparam logic [9:0]  CNT_ZERO  = 10'h000;
    localparam logic [9:0]  CNT_ONE   = 10'h001;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [31:0] ADDR_ZERO = 32'h0000_0000;
    localparam logic        MSB_FIRST = 1'b0;
    localparam logic [2:0]  SYNC_RST  = 3'h4; // select idle high

    typedef enum logic [2:0] {
        SEM_CPU   = 3'b001,
        SEM_FREE  = 3'b010,
        SEM_SLAVE = 3'b100
    } sem_owner_t;

    typedef enum logic [3:0] {
        TR_IDLE   = 4'b0001,
        TR_GRANT  = 4'b0010,
        TR_IGNORE = 4'b0100,
        TR_DRAIN  = 4'b1000
    } tr_state_t;

    typedef struct packed {
        logic cpol;
        logic cpha;
        logic lsb_first;
        logic end_acquire;
    } spi_cfg_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] wdata;
    } mem_cmd_t;

    typedef struct packed {
        logic acquired;
        logic done;
        logic rx_full;
    } evt_t;

endpackage

/* File: sim/serial_slave_unit_properties.sv */
// port assertions for the serial slave unit
// assumes it is bound into every unit instance
`timescale 1ns/1ps

module serial_slave_unit_props (
    // system
    input logic                clk,
    input logic                reset,
    input logic                enable,
    // tasks and status
    input logic                task_acquire,
    input logic                task_release,
    input logic                overflow_clear,
    input sss_pkg::evt_t       events_q,
    input sss_pkg::sem_owner_t sem_owner_q,
    input logic                overflow_q,
    // memory and pins
    input sss_pkg::mem_cmd_t   mem_cmd_q,
    input logic                mem_ack,
    input logic                csn_n,
    input logic                miso_oe_n
);
    // --------------------------------------------
    // semaphore, events and pins
    // --------------------------------------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    grant_next_a: assert property (task_acquire && enable &&
        sem_owner_q != sss_pkg::SEM_SLAVE |=> events_q.acquired) else $error("no grant");
    acq_holder_a: assert property (
        events_q.acquired |-> sem_owner_q == sss_pkg::SEM_CPU) else $error("grant not to cpu");
    release_frees_a: assert property (task_release && !task_acquire && enable &&
        sem_owner_q == sss_pkg::SEM_CPU |=> sem_owner_q == sss_pkg::SEM_FREE) else $error("kept");
    release_idle_a: assert property (task_release && !task_acquire && enable &&
        sem_owner_q == sss_pkg::SEM_FREE |=> sem_owner_q != sss_pkg::SEM_CPU) else $error("taken");
    start_cpu_a: assert property (!enable |=>
        sem_owner_q == sss_pkg::SEM_CPU && !events_q.acquired) else $error("bad start");
    slave_select_a: assert property (sem_owner_q == sss_pkg::SEM_SLAVE &&
        $past(sem_owner_q) != sss_pkg::SEM_SLAVE |-> !$past(csn_n, 2)) else $error("no select");
    done_frees_a: assert property (events_q.done |-> sem_owner_q != sss_pkg::SEM_SLAVE &&
        !mem_cmd_q.req && $past(csn_n, 3)) else $error("early done");
    one_grant_a: assert property (
        events_q.done |=> !events_q.acquired || $past(task_acquire)) else $error("two grants");
    flag_sticky_a: assert property (
        overflow_q && !overflow_clear |=> overflow_q) else $error("flag lost");
    req_holds_a: assert property (mem_cmd_q.req && !mem_ack |=>
        mem_cmd_q.req && $stable(mem_cmd_q.addr)) else $error("request dropped");
    oe_select_a: assert property (miso_oe_n == csn_n) else $error("miso drive");
endmodule

bind serial_slave_unit serial_slave_unit_props props (
    .clk(clk), .reset(reset), .enable(enable), .task_acquire(task_acquire),
    .task_release(task_release), .overflow_clear(overflow_clear), .events_q(events_q),
    .sem_owner_q(sem_owner_q), .overflow_q(overflow_q), .mem_cmd_q(mem_cmd_q),
    .mem_ack(mem_ack), .csn_n(csn_n), .miso_oe_n(miso_oe_n)
);

/* File: sim/spi_master_model.sv */
// external serial master driving select, clock and mosi
// assumes the bench sets the mode pins before each frame
`timescale 1ns/1ps

module spi_master_model (
    // mode
    input  logic cpol,
    input  logic cpha,
    input  logic lsb,
    // pins
    output logic sck,
    output logic csn_n,
    output logic mosi,
    input  logic miso
);
    // --------------------------------------------
    // frame engine
    // --------------------------------------------
    logic [7:0] mo [8];
    logic [7:0] mi [8];

    // idle pins at time zero
    initial begin
        sck = 1'b0;
        csn_n = 1'b1;
        mosi = 1'b0;
    end

    // 15 ns clock idle before select; lead-in covers the prefetch
    task automatic xfer(input int n);
        int k;
        sck = cpol;
        #15 csn_n = 1'b0;
        #100;
        for (int b = 0; b < 8 * n; b++) begin
            k = lsb ? b % 8 : 7 - b % 8;
            if (!cpha) mosi = mo[b / 8][k];
            #15 sck = ~cpol;
            if (cpha) mosi = mo[b / 8][k];
            else mi[b / 8][k] = miso;
            #15 sck = cpol;
            if (cpha) mi[b / 8][k] = miso;
        end
        #15 csn_n = 1'b1;
        mosi = ~mosi; // no stale level
    endtask
endmodule

/* File: sim/serial_slave_unit_tb.sv */
// self-checking bench for the serial slave unit
// assumes master model and checker are compiled first
`timescale 1ns/1ps

module serial_slave_unit_tb;
    // --------------------------------------------
    // signals, memory and counters
    // --------------------------------------------
    logic                clk = 1'b0;
    logic                reset = 1'b1;
    logic                enable = 1'b0;
    logic                acq = 1'b0;
    logic                rel = 1'b0;
    logic                clr = 1'b0;
    logic                ack = 1'b0;
    logic [7:0]          rdata = 8'h00;
    logic [31:0]         rxp = 32'h0000_0080;
    logic [9:0]          txl = 10'h002;
    sss_pkg::spi_cfg_t   cfg = 4'h0;
    sss_pkg::evt_t       ev;
    sss_pkg::sem_owner_t own;
    sss_pkg::mem_cmd_t   mc;
    logic                ovf, txf, sck, csn_n, mosi, so, oe_n;
    logic [9:0]          rxt, txt;
    logic [7:0]          mem [256];
    int                  failures, checked, n_acq, n_done, n_full;
    wire                 miso = oe_n ? 1'bz : so;

    // 200 MHz system clock
    always #2.5 clk = ~clk;

    serial_slave_unit DUT (
        .clk(clk), .reset(reset), .enable(enable), .cfg(cfg),
        .task_acquire(acq), .task_release(rel),
        .rx_buffer_pointer(rxp), .tx_buffer_pointer(32'h0000_0040),
        .rx_byte_limit(10'h003), .tx_byte_limit(txl),
        .tx_excess_flag_char(8'hc3), .ignored_fill_char(8'h3c),
        .overflow_clear(clr), .tx_excess_clear(clr),
        .events_q(ev), .sem_owner_q(own), .overflow_q(ovf), .tx_excess_flag_q(txf),
        .rx_byte_tally_q(rxt), .tx_byte_tally_q(txt),
        .mem_cmd_q(mc), .mem_ack(ack), .mem_rdata(rdata),
        .sck(sck), .csn_n(csn_n), .mosi(mosi), .miso_o(so), .miso_oe_n(oe_n)
    );

    spi_master_model m (
        .cpol(cfg.cpol), .cpha(cfg.cpha), .lsb(cfg.lsb_first),
        .sck(sck), .csn_n(csn_n), .mosi(mosi), .miso(miso)
    );

    // byte memory acking one cycle after each request
    always @(posedge clk) begin
        ack <= mc.req && !ack;
        rdata <= mem[mc.addr[7:0]];
        if (mc.req && ack && mc.we) mem[mc.addr[7:0]] <= mc.wdata;
    end

    // event pulses are only one cycle wide, so tally them here
    always @(posedge clk) begin
        if (ev.acquired === 1'b1) n_acq++;
        if (ev.done === 1'b1) n_done++;
        if (ev.rx_full === 1'b1) n_full++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one-cycle task pulses, then let the answer land
    task automatic pulse(input logic a, input logic r, input logic c);
        @(posedge clk);
        acq <= a;
        rel <= r;
        clr <= c;
        @(posedge clk);
        acq <= 1'b0;
        rel <= 1'b0;
        clr <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // frame in mode c; bounded wait for done when one is due
    task automatic frame(input int n, input logic [3:0] c, input logic wd);
        int d0;
        int i;
        @(posedge clk);
        cfg <= c;
        @(negedge clk);
        d0 = n_done;
        m.xfer(n);
        for (i = 0; i < 60 && wd && n_done == d0; i++) @(negedge clk);
        if (wd && n_done == d0) begin
            failures++;
            print_verdict();
        end
        repeat (30) @(negedge clk);
    endtask

    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        enable <= 1'b1;
        repeat (3) @(negedge clk);
        check({own, n_acq[7:0]}, {sss_pkg::SEM_CPU, 8'h00});
        pulse(1'b1, 1'b0, 1'b0);
        check(n_acq, 1);
        m.mo[0] = 8'h11;
        m.mo[1] = 8'h22;
        frame(2, 4'h0, 1'b0);
        check({m.mi[0], m.mi[1], mem[8'h80]}, 24'h3c3cda);
        pulse(1'b0, 1'b1, 1'b0);
        check(own, sss_pkg::SEM_FREE);
        pulse(1'b0, 1'b1, 1'b0);
        check(own, sss_pkg::SEM_FREE);
        for (int md = 0; md < 4; md++) begin
            for (int j = 0; j < 4; j++) m.mo[j] = 8'(16 * md + j + 1);
            frame(4, {2'(md), 1'(md == 1 || md == 2), 1'b0}, 1'b1);
            for (int j = 0; j < 4; j++) check(m.mi[j], j < 2 ? mem[8'h40 + j] : 8'hc3);
            check({mem[8'h80], mem[8'h81], mem[8'h82], mem[8'h83]},
                  {m.mo[0], m.mo[1], m.mo[2], 8'hd9});
            check({rxt, txt, ovf, txf}, {10'h003, 10'h002, 2'b11});
            check({own, n_full[7:0]}, {sss_pkg::SEM_FREE, 8'(md + 1)});
            pulse(1'b0, 1'b0, 1'b1);
            check({ovf, txf}, 2'b00);
        end
        @(posedge clk);
        rxp <= 32'h0000_0090;
        txl <= 10'h000;
        m.mo[0] = 8'h77;
        fork
            frame(1, 4'h1, 1'b1);
            begin
                repeat (40) @(negedge clk);
                pulse(1'b1, 1'b0, 1'b0);
                check(own, sss_pkg::SEM_SLAVE);
                pulse(1'b1, 1'b0, 1'b0);
                check(n_acq, 1);
            end
        join
        check({own, n_acq[7:0], n_done[7:0]}, {sss_pkg::SEM_CPU, 16'h0205});
        check({mem[8'h90], m.mi[0]}, 16'h77c3);
        check({rxt, txt, txf}, {10'h001, 10'h000, 1'b1});
        print_verdict();
    end
endmodule
